// ### crb_pkg.sv
/*
  crb_pkg: constants shared by the receive buffering block and its testbench.
  assumes a single 20 MHz device clock and an 8-bit register port.
*/
package crb_pkg;
  // receive mode encodings
  localparam logic [1:0] MODE_FILTERED = 2'h0;
  localparam logic [1:0] MODE_STD_ONLY = 2'h1;
  localparam logic [1:0] MODE_EXT_ONLY = 2'h2;
  localparam logic [1:0] MODE_ANY = 2'h3;
  // field positions in the buffer control registers
  localparam int RXM_LSB = 5;
  localparam int RTR_BIT = 3;
  localparam int ROLL_BIT = 2;
  localparam int ROLL_COPY_BIT = 1;
  // field positions in the full pin control register
  localparam int PIN_MODE_LSB = 0;
  localparam int PIN_EN_LSB = 2;
  localparam int PIN_STATE_LSB = 4;
  // register indices on the register port
  localparam logic [2:0] REG_HIGH_PRIORITY_RX_BUFFER_CTRL = 3'h0;
  localparam logic [2:0] REG_LOW_PRIORITY_RX_BUFFER_CTRL = 3'h1;
  localparam logic [2:0] REG_PIN_CTRL = 3'h2;
  localparam logic [2:0] REG_INT_EN = 3'h3;
  localparam logic [2:0] REG_INT_FLAG = 3'h4;
  localparam logic [2:0] REG_ERR_FLAG = 3'h5;
  // values after reset
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] PIN_RESET = 8'h00;
  localparam logic [1:0] IEN_RESET = 2'h0;
  // number of filters per buffer
  localparam int HI_FILTERS = 2;
  localparam int LO_FILTERS = 4;
endpackage : crb_pkg

// ### crb_fifo.sv
/*
  crb_fifo: small synchronous fifo with valid/ready on both sides.
  assumes one clock and synchronous active low reset.
*/
`timescale 1ns/1ps
module crb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // handshake terms
  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_ptr];

  // storage
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : crb_fifo

// ### crb_rx_buffering.sv
/*
  crb_rx_buffering: assembly store, two prioritized receive buffers, full flags,
  interrupt and buffer full pins of a standalone can controller.
  assumes the protocol engine streams frame bytes on the clock, with start, end
  and error marks, and delivers the filter match vectors at frame end; the
  serial register port is decoded outside into an 8-bit read/write strobe port.
*/
`timescale 1ns/1ps
module crb_rx_buffering #(
  parameter int FRAME_BYTES = 13,
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // byte stream from the protocol engine
  input wire logic RX_VALID_I,
  output logic RX_READY_O,
  input wire logic [7:0] RX_DATA_I,
  input wire logic RX_SOF_I,
  input wire logic RX_EOF_I,
  input wire logic RX_ERR_I,
  // frame attributes at end of frame
  input wire logic RX_EXT_I,
  input wire logic RX_RTR_I,
  input wire logic [5:0] FILT_HIT_I,
  input wire logic [5:0] FILT_EXT_I,
  // register port
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [2:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,
  // buffer data read port
  input wire logic BUF_SEL_I,
  input wire logic [3:0] BUF_IDX_I,
  output logic [7:0] BUF_DATA_O,
  // pins
  output logic INT_N_O,
  output logic BUF0_FULL_N_O,
  output logic BUF1_FULL_N_O,
  output logic OVERFLOW_O
);
  logic [7:0] asm_store [FRAME_BYTES];
  logic [7:0] hi_buf [FRAME_BYTES];
  logic [7:0] lo_buf [FRAME_BYTES];
  logic [3:0] wr_idx;
  logic f_valid;
  logic f_ready;
  logic [7:0] f_data;
  logic [1:0] mode0;
  logic [1:0] mode1;
  logic roll_en;
  logic [3:0] stat0;
  logic [3:0] stat1;
  logic [1:0] rx_full_flag;
  logic [1:0] rx_full_irq_enable;
  logic [1:0] ovf_flag;
  logic [5:0] pin_ctrl;
  logic ev_done;
  logic [5:0] hit_ok;
  logic hit0;
  logic hit1;
  logic [2:0] idx0;
  logic [2:0] idx1;
  logic take0;
  logic take1;
  logic roll;
  logic ovf0;
  logic ovf1;
  logic [1:0] next_full;

  // engine bytes are buffered before the assembly store
  crb_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .in_valid_i(RX_VALID_I),
    .in_ready_o(RX_READY_O),
    .in_data_i(RX_DATA_I),
    .out_valid_o(f_valid),
    .out_ready_i(f_ready),
    .out_data_o(f_data)
  );
  // drain stalls while a frame end is decided
  assign f_ready = !ev_done;

  // assembly store fills regardless of buffer state
  always_ff @(posedge CLK_I) begin
    if (f_valid && f_ready && wr_idx < 4'(FRAME_BYTES)) begin
      asm_store[wr_idx] <= f_data;
    end
  end

  // write index restarts at frame start
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      wr_idx <= 4'h0;
    end else if (RX_SOF_I) begin
      wr_idx <= 4'h0;
    end else if (f_valid && f_ready && wr_idx < 4'(FRAME_BYTES)) begin
      wr_idx <= wr_idx + 4'h1;
    end
  end

  // frame end event: good end, or error while the high priority buffer is in mode 11
  assign ev_done = RX_EOF_I || (RX_ERR_I && mode0 == crb_pkg::MODE_ANY);

  // filter qualification by receive mode per filter
  for (genvar g = 0; g < 6; g++) begin : g_filt
    logic [1:0] m;
    assign m = (g < crb_pkg::HI_FILTERS) ? mode0 : mode1;
    assign hit_ok[g] = FILT_HIT_I[g] && (FILT_EXT_I[g] == RX_EXT_I) &&
      !(m == crb_pkg::MODE_STD_ONLY && FILT_EXT_I[g]) &&
      !(m == crb_pkg::MODE_EXT_ONLY && !FILT_EXT_I[g]);
  end

  // acceptance and destination choice
  always_comb begin
    hit0 = (|hit_ok[1:0]) || mode0 == crb_pkg::MODE_ANY;
    hit1 = (|hit_ok[5:2]) || mode1 == crb_pkg::MODE_ANY;
    idx0 = hit_ok[0] ? 3'h0 : 3'h1;
    idx1 = hit_ok[2] ? 3'h2 : hit_ok[3] ? 3'h3 : hit_ok[4] ? 3'h4 : 3'h5;
    roll = roll_en && hit0 && rx_full_flag[0];
    take0 = ev_done && hit0 && !rx_full_flag[0];
    take1 = ev_done && !take0 && (hit1 || roll) && !rx_full_flag[1];
    ovf0 = ev_done && hit0 && rx_full_flag[0] && !roll;
    ovf1 = ev_done && !take0 && (hit1 || roll) && rx_full_flag[1];
    if (roll) begin
      idx1 = idx0;
    end
  end

  // whole-buffer copy on acceptance
  always_ff @(posedge CLK_I) begin
    for (int i = 0; i < FRAME_BYTES; i++) begin
      if (take0) begin
        hi_buf[i] <= asm_store[i];
      end
      if (take1) begin
        lo_buf[i] <= asm_store[i];
      end
    end
  end

  // full flags: hardware set wins over host clear
  always_comb begin
    next_full = rx_full_flag;
    if (REG_WR_I && REG_ADDR_I == crb_pkg::REG_INT_FLAG) begin
      next_full = rx_full_flag & REG_WDATA_I[1:0];
    end
    if (take0) begin
      next_full[0] = 1'b1;
    end
    if (take1) begin
      next_full[1] = 1'b1;
    end
  end

  // status and flag registers
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      rx_full_flag <= 2'h0;
      ovf_flag <= 2'h0;
      stat0 <= 4'h0;
      stat1 <= 4'h0;
    end else begin
      rx_full_flag <= next_full;
      if (REG_WR_I && REG_ADDR_I == crb_pkg::REG_ERR_FLAG) begin
        ovf_flag <= (ovf_flag & REG_WDATA_I[1:0]) | {ovf1, ovf0};
      end else begin
        ovf_flag <= ovf_flag | {ovf1, ovf0};
      end
      if (take0) begin
        stat0 <= {RX_RTR_I, 2'h0, idx0[0]};
      end
      if (take1) begin
        stat1 <= {RX_RTR_I, idx1};
      end
    end
  end

  // host writable configuration
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      mode0 <= crb_pkg::CTRL_RESET[6:5];
      mode1 <= crb_pkg::CTRL_RESET[6:5];
      roll_en <= crb_pkg::CTRL_RESET[2];
      pin_ctrl <= crb_pkg::PIN_RESET[5:0];
      rx_full_irq_enable <= crb_pkg::IEN_RESET;
    end else if (REG_WR_I) begin
      case (REG_ADDR_I)
        crb_pkg::REG_HIGH_PRIORITY_RX_BUFFER_CTRL: begin
          mode0 <= REG_WDATA_I[crb_pkg::RXM_LSB +: 2];
          roll_en <= REG_WDATA_I[crb_pkg::ROLL_BIT];
        end
        crb_pkg::REG_LOW_PRIORITY_RX_BUFFER_CTRL: mode1 <= REG_WDATA_I[crb_pkg::RXM_LSB +: 2];
        crb_pkg::REG_PIN_CTRL: pin_ctrl <= REG_WDATA_I[5:0];
        crb_pkg::REG_INT_EN: rx_full_irq_enable <= REG_WDATA_I[1:0];
        default: ;
      endcase
    end
  end

  // register read mux, registered data
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (REG_RD_I) begin
      case (REG_ADDR_I)
        crb_pkg::REG_HIGH_PRIORITY_RX_BUFFER_CTRL: REG_RDATA_O <= {1'b0, mode0, 1'b0, stat0[3], roll_en,
          roll_en, stat0[0]};
        crb_pkg::REG_LOW_PRIORITY_RX_BUFFER_CTRL: REG_RDATA_O <= {1'b0, mode1, 1'b0, stat1};
        crb_pkg::REG_PIN_CTRL: REG_RDATA_O <= {2'h0,
          pin_ctrl[5] & ~pin_ctrl[1], pin_ctrl[4] & ~pin_ctrl[0], pin_ctrl[3:0]};
        crb_pkg::REG_INT_EN: REG_RDATA_O <= {6'h00, rx_full_irq_enable};
        crb_pkg::REG_INT_FLAG: REG_RDATA_O <= {6'h00, rx_full_flag};
        crb_pkg::REG_ERR_FLAG: REG_RDATA_O <= {6'h00, ovf_flag};
        default: REG_RDATA_O <= 8'h00;
      endcase
    end
  end

  // buffer data read, either buffer while the other receives
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      BUF_DATA_O <= 8'h00;
    end else if (BUF_IDX_I < 4'(FRAME_BYTES)) begin
      BUF_DATA_O <= BUF_SEL_I ? lo_buf[BUF_IDX_I] : hi_buf[BUF_IDX_I];
    end else begin
      BUF_DATA_O <= 8'h00;
    end
  end

  // interrupt and buffer full pins, idle high when disabled
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      INT_N_O <= 1'b1;
      BUF0_FULL_N_O <= 1'b1;
      BUF1_FULL_N_O <= 1'b1;
      OVERFLOW_O <= 1'b0;
    end else begin
      INT_N_O <= !(|(next_full & rx_full_irq_enable));
      BUF0_FULL_N_O <= !pin_ctrl[2] ? 1'b1 : pin_ctrl[0] ? !next_full[0]
        : pin_ctrl[4];
      BUF1_FULL_N_O <= !pin_ctrl[3] ? 1'b1 : pin_ctrl[1] ? !next_full[1]
        : pin_ctrl[5];
      OVERFLOW_O <= |(ovf_flag | {ovf1, ovf0});
    end
  end

  // checks; the pins lag a register write by one cycle, hence the past and stable terms
  chk_full_set: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    take0 |=> rx_full_flag[0]) else $error("full flag not set on load");
  chk_no_load_full: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    rx_full_flag[1] |-> !take1) else $error("load into full buffer");
  chk_int_pin: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (rx_full_flag[0] && $past(rx_full_irq_enable[0])) |-> !INT_N_O)
    else $error("interrupt pin not asserted");
  chk_roll_dest: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (ev_done && roll && !rx_full_flag[1]) |-> take1 && !ovf0)
    else $error("rollover not taken");
  chk_ovf_raise: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    ovf0 |=> ovf_flag[0] && OVERFLOW_O) else $error("overflow lost");
  chk_mode_any: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (ev_done && mode0 == crb_pkg::MODE_ANY && !rx_full_flag[0]) |-> take0)
    else $error("mode 11 frame dropped");
  chk_pin_irq: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (pin_ctrl[2] && pin_ctrl[0] && rx_full_flag[0] && $stable(pin_ctrl)) |-> !BUF0_FULL_N_O)
    else $error("pin not following flag");
  chk_pin_out: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (pin_ctrl[3] && !pin_ctrl[1] && $stable(pin_ctrl)) |-> BUF1_FULL_N_O == pin_ctrl[5])
    else $error("output pin state wrong");
  chk_std_only: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (mode1 == crb_pkg::MODE_STD_ONLY) |-> !(|(hit_ok[5:2] & FILT_EXT_I[5:2])))
    else $error("extended filter matched in mode 01");
  chk_pin_off: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (!pin_ctrl[2] && $stable(pin_ctrl)) |-> BUF0_FULL_N_O)
    else $error("disabled pin not high");
  chk_hi_first: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (ev_done && hit0 && !rx_full_flag[0]) |-> take0 && !take1)
    else $error("low buffer took a high buffer frame");
  chk_asm_fill: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (f_valid && f_ready && !RX_SOF_I && wr_idx < 4'(FRAME_BYTES))
    |=> wr_idx == $past(wr_idx) + 4'h1) else $error("assembly index stalled");
endmodule : crb_rx_buffering

// ### crb_host_model.sv
/*
  crb_host_model: host side of the register port and the buffer read port.
  assumes the bench calls its tasks; every change is made at a falling edge.
*/
`timescale 1ns/1ps
module crb_host_model (
  // clock
  input wire logic clk_i,
  // register port
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [2:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i,
  // buffer read port
  output logic buf_sel_o,
  output logic [3:0] buf_idx_o,
  input wire logic [7:0] buf_data_i,
  // read results, one cycle pulse
  output logic got_o,
  output logic [7:0] got_data_o
);
  // idle levels
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 3'h0;
    reg_wdata_o = 8'h00;
    buf_sel_o = 1'b0;
    buf_idx_o = 4'h0;
    got_o = 1'b0;
    got_data_o = 8'h00;
  end

  // single write strobe, also used to clear full flags
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
  endtask : wr

  // register or buffer read, result shown as a pulse
  task automatic rd(input logic b, input logic s, input logic [3:0] a);
    @(negedge clk_i);
    buf_sel_o = s;
    buf_idx_o = a;
    reg_addr_o = a[2:0];
    reg_rd_o = ~b;
    @(negedge clk_i);
    reg_rd_o = 1'b0;
    got_data_o = b ? buf_data_i : reg_rdata_i;
    got_o = 1'b1;
    @(negedge clk_i);
    got_o = 1'b0;
  endtask : rd

  // read, change masked bits, write back; keeps other pin states steady
  task automatic modify(input logic [2:0] a, input logic [7:0] m, input logic [7:0] d);
    logic [7:0] old;
    @(negedge clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge clk_i);
    reg_rd_o = 1'b0;
    old = reg_rdata_i;
    wr(a, (old & ~m) | (d & m));
  endtask : modify
endmodule : crb_host_model

// ### test_crb_rx_buffering.sv
/*
  test_crb_rx_buffering: self-checking bench for the receive buffering block.
  assumes crb_pkg and crb_host_model; frames are fed byte by byte as the engine.
*/
`timescale 1ns/1ps
module test_crb_rx_buffering;
  localparam int DEPTH = 8;
  logic CLK_I = 1'b0, RST_N_I = 1'b0, RX_VALID_I = 1'b0, RX_SOF_I = 1'b0;
  logic RX_EOF_I = 1'b0, RX_ERR_I = 1'b0, RX_EXT_I = 1'b0, RX_RTR_I = 1'b0;
  logic [7:0] RX_DATA_I = 8'h00;
  logic [5:0] FILT_HIT_I = 6'h00, FILT_EXT_I = 6'h00;
  logic RX_READY_O, INT_N_O, BUF0_FULL_N_O, BUF1_FULL_N_O, OVERFLOW_O, wr, rd, sel, got;
  logic [2:0] addr;
  logic [3:0] idx;
  logic [7:0] wd, rdat, bdat, got_data, b0, fb[16];
  logic [7:0] q[$];
  string qn[$];
  integer seed = 32'hf6a79252;
  int failures = 0, n_tests = 0;

  // clock
  always #25 CLK_I = ~CLK_I;

  crb_rx_buffering #(.FIFO_DEPTH(DEPTH)) crb_rx_buffering_inst (.CLK_I(CLK_I),
    .RST_N_I(RST_N_I), .RX_VALID_I(RX_VALID_I), .RX_READY_O(RX_READY_O),
    .RX_DATA_I(RX_DATA_I), .RX_SOF_I(RX_SOF_I), .RX_EOF_I(RX_EOF_I), .RX_ERR_I(RX_ERR_I),
    .RX_EXT_I(RX_EXT_I), .RX_RTR_I(RX_RTR_I), .FILT_HIT_I(FILT_HIT_I),
    .FILT_EXT_I(FILT_EXT_I), .REG_WR_I(wr), .REG_RD_I(rd), .REG_ADDR_I(addr),
    .REG_WDATA_I(wd), .REG_RDATA_O(rdat), .BUF_SEL_I(sel), .BUF_IDX_I(idx),
    .BUF_DATA_O(bdat), .INT_N_O(INT_N_O), .BUF0_FULL_N_O(BUF0_FULL_N_O),
    .BUF1_FULL_N_O(BUF1_FULL_N_O), .OVERFLOW_O(OVERFLOW_O));

  crb_host_model crb_host_model_inst (.clk_i(CLK_I), .reg_wr_o(wr), .reg_rd_o(rd),
    .reg_addr_o(addr), .reg_wdata_o(wd), .reg_rdata_i(rdat), .buf_sel_o(sel),
    .buf_idx_o(idx), .buf_data_i(bdat), .got_o(got), .got_data_o(got_data));

  task automatic give_verdict();
    if (failures == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  task automatic chk_data(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk_data

  // pins as {int, full0, full1, overflow}, one cycle after the cause
  task automatic chk_pins(input logic [3:0] e);
    @(negedge CLK_I);
    chk_data("pins", {4'h0, e}, {4'h0, INT_N_O, BUF0_FULL_N_O, BUF1_FULL_N_O, OVERFLOW_O});
  endtask : chk_pins

  // note the expectation, then read
  task automatic ex(input logic b, input logic s, input logic [3:0] a, input logic [7:0] v,
                    input string nm);
    q.push_back(v);
    qn.push_back(nm);
    crb_host_model_inst.rd(b, s, a);
  endtask : ex

  // compare each read result with the oldest note
  always @(posedge CLK_I) begin
    if (got === 1'b1) begin
      chk_data(qn.pop_front(), q.pop_front(), got_data);
    end
  end

  // one frame: start mark, random bytes through the fifo, then end or error mark
  task automatic frame(input int n, input logic e, input logic r, input logic [5:0] h,
                       input logic [5:0] f, input logic er);
    int k;
    @(negedge CLK_I);
    RX_SOF_I = 1'b1;
    @(negedge CLK_I);
    RX_SOF_I = 1'b0;
    for (int i = 0; i < n; i++) begin
      RX_VALID_I = 1'b1;
      RX_DATA_I = 8'($random(seed));
      fb[i] = RX_DATA_I;
      k = 0;
      while (RX_READY_O !== 1'b1) begin
        @(negedge CLK_I);
        k++;
        if (k > 50) begin
          failures++;
          give_verdict();
        end
      end
      @(negedge CLK_I);
    end
    RX_VALID_I = 1'b0;
    repeat (DEPTH + 2) @(negedge CLK_I);
    {RX_EXT_I, RX_RTR_I, FILT_HIT_I, FILT_EXT_I} = {e, r, h, f};
    RX_EOF_I = ~er;
    RX_ERR_I = er;
    @(negedge CLK_I);
    RX_EOF_I = 1'b0;
    RX_ERR_I = 1'b0;
  endtask : frame

  // watchdog
  initial begin
    #3000000;
    failures++;
    give_verdict();
  end

  // main sequence
  initial begin
    repeat (4) @(negedge CLK_I);
    RST_N_I = 1'b1;
    for (int a = 0; a < 8; a++) begin
      ex(0, 0, a, a == 2 ? crb_pkg::PIN_RESET : a < 2 ? crb_pkg::CTRL_RESET : 8'h00,
         "reset");
    end
    chk_pins(4'he);
    crb_host_model_inst.wr(crb_pkg::REG_INT_EN, 8'h03);
    crb_host_model_inst.wr(crb_pkg::REG_PIN_CTRL, 8'h3f);
    ex(0, 0, crb_pkg::REG_PIN_CTRL, 8'h0f, "pinctl");
    frame(13, 0, 0, 6'h01, 6'h00, 0);
    chk_pins(4'h2);
    ex(0, 0, crb_pkg::REG_INT_FLAG, 8'h01, "flags");
    ex(0, 0, crb_pkg::REG_HIGH_PRIORITY_RX_BUFFER_CTRL, 8'h00, "ctrl0");
    for (int i = 0; i < 14; i++) begin
      ex(1, 0, i, i < 13 ? fb[i] : 8'h00, "buf0");
    end
    b0 = fb[0];
    frame(13, 0, 1, 6'h02, 6'h00, 0);
    chk_pins(4'h3);
    ex(0, 0, crb_pkg::REG_ERR_FLAG, 8'h01, "ovf");
    ex(1, 0, 0, b0, "held");
    crb_host_model_inst.wr(crb_pkg::REG_INT_FLAG, 8'hfe);
    crb_host_model_inst.wr(crb_pkg::REG_ERR_FLAG, 8'h00);
    chk_pins(4'he);
    frame(8, 1, 1, 6'h02, 6'h02, 0);
    ex(0, 0, crb_pkg::REG_HIGH_PRIORITY_RX_BUFFER_CTRL, 8'h09, "ctrl0");
    b0 = fb[0];
    crb_host_model_inst.wr(crb_pkg::REG_HIGH_PRIORITY_RX_BUFFER_CTRL, 8'h04);
    ex(0, 0, crb_pkg::REG_HIGH_PRIORITY_RX_BUFFER_CTRL, 8'h0f, "ctrl0");
    frame(13, 0, 0, 6'h01, 6'h00, 0);
    chk_pins(4'h0);
    ex(0, 0, crb_pkg::REG_LOW_PRIORITY_RX_BUFFER_CTRL, 8'h00, "ctrl1");
    ex(1, 1, 12, fb[12], "buf1");
    ex(1, 0, 0, b0, "buf0");
    crb_host_model_inst.wr(crb_pkg::REG_INT_EN, 8'h00);
    chk_pins(4'h8);
    crb_host_model_inst.wr(crb_pkg::REG_INT_EN, 8'h03);
    crb_host_model_inst.wr(crb_pkg::REG_INT_FLAG, 8'h00);
    // modes: {mode, frame ext, filter ext, taken}
    for (int m = 0; m < 5; m++) begin
      logic [4:0] t;
      t = m == 0 ? 5'h0a : m == 1 ? 5'h0e : m == 2 ? 5'h10 : m == 3 ? 5'h09 : 5'h17;
      crb_host_model_inst.wr(crb_pkg::REG_HIGH_PRIORITY_RX_BUFFER_CTRL, {1'b0, t[4:3], 5'h00});
      frame(4, t[2], 0, 6'h01, {5'h00, t[1]}, 0);
      chk_pins(t[0] ? 4'h2 : 4'he);
      crb_host_model_inst.wr(crb_pkg::REG_INT_FLAG, 8'h00);
    end
    crb_host_model_inst.wr(crb_pkg::REG_HIGH_PRIORITY_RX_BUFFER_CTRL, {1'b0, crb_pkg::MODE_ANY, 5'h00});
    frame(5, 0, 0, 6'h00, 6'h00, 1);
    chk_pins(4'h2);
    for (int i = 0; i < 5; i++) begin
      ex(1, 0, i, fb[i], "part");
    end
    crb_host_model_inst.wr(crb_pkg::REG_INT_FLAG, 8'h00);
    crb_host_model_inst.wr(crb_pkg::REG_HIGH_PRIORITY_RX_BUFFER_CTRL, 8'h00);
    for (int f = 2; f < 6; f++) begin
      frame(3, 0, 0, 6'h01 << f, 6'h00, 0);
      ex(0, 0, crb_pkg::REG_LOW_PRIORITY_RX_BUFFER_CTRL, 8'(f), "ctrl1");
      chk_pins(4'h4);
      crb_host_model_inst.wr(crb_pkg::REG_INT_FLAG, 8'h00);
    end
    // second buffer in standard-only mode refuses an extended filter hit
    crb_host_model_inst.wr(crb_pkg::REG_LOW_PRIORITY_RX_BUFFER_CTRL, {1'b0, crb_pkg::MODE_STD_ONLY, 5'h00});
    frame(3, 1, 0, 6'h04, 6'h04, 0);
    chk_pins(4'he);
    ex(0, 0, crb_pkg::REG_LOW_PRIORITY_RX_BUFFER_CTRL, 8'h25, "ctrl1");
    crb_host_model_inst.wr(crb_pkg::REG_LOW_PRIORITY_RX_BUFFER_CTRL, 8'h00);
    crb_host_model_inst.wr(crb_pkg::REG_PIN_CTRL, 8'h0c);
    chk_pins(4'h8);
    crb_host_model_inst.modify(crb_pkg::REG_PIN_CTRL, 8'h10, 8'h10);
    chk_pins(4'hc);
    ex(0, 0, crb_pkg::REG_PIN_CTRL, 8'h1c, "pinctl");
    repeat (4) @(negedge CLK_I);
    give_verdict();
  end
endmodule : test_crb_rx_buffering
